// ---- verilog/uart_rx_brk.sv ----
// UART receiver with break transmitter, and the FIFO both paths use.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Generic FIFO with valid/ready on both sides and a flush.
// ----------------------------------------------------------------
module data_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic mclk, // System clock.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic flush, // Discards every stored word.
    input wire logic in_valid, // Write side offers a word.
    output logic in_ready, // Room for a word.
    input wire logic [WIDTH-1:0] in_data, // Word to store.
    output logic out_valid, // Oldest word available.
    input wire logic out_ready, // Drain side takes the word.
    output logic [WIDTH-1:0] out_data, // Oldest word.
    output logic [$clog2(DEPTH+1)-1:0] count // Words held.
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("data_fifo needs DEPTH of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = (cnt_reg != CW'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
    assign count = cnt_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (flush) begin
            wr_next = '0;
            rd_next = '0;
            cnt_next = '0;
        end else begin
            if (push) begin
                wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_next = cnt_reg + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (push && !flush) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule : data_fifo

// ----------------------------------------------------------------
// Receiver, receive FIFO, transmit FIFO and break-capable shifter.
// ----------------------------------------------------------------
module uart_rx_brk
    import uart_rx_brk_pkg::*;
#(
    parameter int RX_DEPTH = RX_FIFO_DEPTH,
    parameter int TX_DEPTH = TX_FIFO_DEPTH
) (
    input wire logic mclk, // 20 MHz system clock.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic sample_tick, // Baud sample enable, 16x or 4x.
    input wire logic module_enable, // Whole block enabled.
    input wire logic transmit_enable, // Transmitter enabled.
    input wire logic high_speed_sel, // 1 selects 4x sampling.
    input wire logic [1:0] data_parity_sel, // Data and parity format.
    input wire logic stop_bits_sel, // 1 sends two stop bits.
    input wire logic [1:0] rx_irq_select, // Receive interrupt level.
    input wire logic break_set, // Pulse: request a break.
    input wire logic serial_in_pin, // Serial line in.
    input wire logic tx_valid, // Transmit word offered.
    input wire logic [DATA_W-1:0] tx_data, // Transmit word.
    output logic tx_ready, // Transmit FIFO has room.
    input wire logic rx_read, // Pulse: pop receive word.
    input wire logic overrun_clear, // Pulse: software clears overrun.
    output logic [DATA_W-1:0] rx_data, // Word at the FIFO head.
    output rx_status_t status, // Receive status flags.
    output logic shift_empty, // Transmit shifter empty.
    output logic break_request, // Break pending or sending.
    output logic serial_out_pin, // Serial line out.
    output logic serial_out_oe, // Drive enable of the line.
    output logic rx_irq_flag, // Pulse: receive interrupt.
    output logic error_irq, // Pulse: receive error interrupt.
    output logic tx_irq_flag // Pulse: character sent.
);
    initial begin
        if (RX_DEPTH < 2 || RX_DEPTH > 7 || TX_DEPTH < 2) begin
            $error("uart_rx_brk depth parameters out of range");
        end
    end

    localparam int RCW = $clog2(RX_DEPTH+1);
    localparam int TCW = $clog2(TX_DEPTH+1);

    // ------------------------------------------------------------
    // Receive path.
    // ------------------------------------------------------------
    rx_state_t rx_state_reg, rx_state_next;
    logic [4:0] rx_phase_reg, rx_phase_next;
    logic [3:0] rx_bits_reg, rx_bits_next;
    logic [DATA_W-1:0] rsr_reg, rsr_next;
    logic [1:0] maj_reg, maj_next;
    logic prev_in_reg, overrun_reg, overrun_next;
    logic bit_val, bit_ready, bit_end, nine_bits, ovr_set;
    logic rx_push, rx_full, framing_flag_cur, parity_flag_cur;
    logic [4:0] ticks_per_bit;
    logic [3:0] rx_nbits;
    logic [RCW-1:0] rx_count;
    rx_entry_t rx_in, rx_head;
    logic rx_head_valid;

    assign nine_bits = (data_parity_sel == PSEL_NINE); // [RULE23]
    assign ticks_per_bit = high_speed_sel ? TICKS_4X : TICKS_16X;
    assign rx_nbits = (data_parity_sel == PSEL_NONE) ? RX_BITS_8 : RX_BITS_9;
    assign bit_end = sample_tick && (rx_phase_reg == ticks_per_bit);
    // 16x judges by majority of three ticks, 4x by one mid-bit tick.
    assign bit_ready = sample_tick && (high_speed_sel ?
        (rx_phase_reg == HALF_4X) : (rx_phase_reg == MAJ_THIRD)); // [RULE10]
    assign bit_val = high_speed_sel ? serial_in_pin :
        ((maj_reg[0] & maj_reg[1]) | (serial_in_pin &
        (maj_reg[0] | maj_reg[1]))); // [RULE9]
    assign framing_flag_cur = !bit_val; // [RULE15]
    always_comb begin
        parity_flag_cur = 1'b0;
        if (data_parity_sel == PSEL_EVEN) begin
            parity_flag_cur = ^rsr_reg;
        end else if (data_parity_sel == PSEL_ODD) begin
            parity_flag_cur = ~^rsr_reg;
        end
    end

    // The word plus its own error bits, so status follows the head.
    assign rx_in = '{parity_err: parity_flag_cur, framing_err: framing_flag_cur,
        data: (nine_bits ? rsr_reg : {1'b0, rsr_reg[7:0]})}; // [RULE17]
    assign rx_push = (rx_state_reg == RX_STOP) && bit_ready && !rx_full
        && !overrun_reg; // [RULE11] [RULE13]
    assign ovr_set = (rx_state_reg == RX_STOP) && bit_ready
        && rx_full && !overrun_reg; // [RULE13]

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_phase_next = rx_phase_reg;
        rx_bits_next = rx_bits_reg;
        rsr_next = rsr_reg;
        maj_next = maj_reg;
        if (sample_tick) begin
            rx_phase_next = bit_end ? 5'h01 : rx_phase_reg + 5'h01;
            if (rx_phase_reg == MAJ_FIRST) begin
                maj_next[0] = serial_in_pin;
            end
            if (rx_phase_reg == MAJ_SECOND) begin
                maj_next[1] = serial_in_pin;
            end
        end
        case (rx_state_reg)
            RX_IDLE: begin
                // Edge tick counts as tick 1 of the start bit.
                if (sample_tick && prev_in_reg && !serial_in_pin
                    && module_enable && !overrun_reg) begin
                    rx_state_next = RX_START; // [RULE25]
                    rx_phase_next = 5'h02;
                end
            end
            RX_START: begin
                if (bit_ready && bit_val) begin
                    rx_state_next = RX_IDLE;
                end else if (bit_end) begin
                    rx_state_next = RX_DATA;
                    rx_bits_next = '0;
                end
            end
            RX_DATA: begin
                if (bit_ready) begin
                    rsr_next = (rx_nbits == RX_BITS_9) ?
                        {bit_val, rsr_reg[8:1]} : {1'b0, bit_val, rsr_reg[7:1]};
                    rx_bits_next = rx_bits_reg + 4'h1;
                end
                if (bit_end && rx_bits_reg == rx_nbits) begin
                    rx_state_next = RX_STOP;
                end
            end
            RX_STOP: begin
                if (bit_ready) begin
                    rx_state_next = RX_IDLE;
                end
            end
            default: rx_state_next = RX_IDLE;
        endcase
        if (!module_enable) begin
            rx_state_next = RX_IDLE;
        end
    end

    // Overrun set wins over a clear arriving in the same cycle.
    assign overrun_next = ovr_set || (overrun_reg && !overrun_clear);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rx_state_reg <= RX_IDLE;
            rx_phase_reg <= 5'h01;
            rx_bits_reg <= '0;
            rsr_reg <= '0;
            maj_reg <= '0;
            prev_in_reg <= 1'b1;
            overrun_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_phase_reg <= rx_phase_next;
            rx_bits_reg <= rx_bits_next;
            rsr_reg <= rsr_next;
            maj_reg <= maj_next;
            prev_in_reg <= sample_tick ? serial_in_pin : prev_in_reg;
            overrun_reg <= overrun_next;
        end
    end

    data_fifo #(.WIDTH($bits(rx_entry_t)), .DEPTH(RX_DEPTH)) rx_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .flush(overrun_reg && overrun_clear && !ovr_set), // [RULE14]
        .in_valid(rx_push),
        .in_ready(),
        .in_data(rx_in),
        .out_valid(rx_head_valid),
        .out_ready(rx_read),
        .out_data(rx_head),
        .count(rx_count)
    ); // [RULE12]
    assign rx_full = (rx_count == RCW'(RX_DEPTH));

    logic rx_irq_cond, err_cond;
    always_comb begin
        case (rx_irq_select) // [RULE19] [RULE20]
            RXI_THREE: rx_irq_cond = (rx_count >= RCW'(RX_LEVEL_THREE - 3'h1));
            RXI_FULL: rx_irq_cond = (rx_count == RCW'(RX_DEPTH - 1));
            default: rx_irq_cond = 1'b1;
        endcase
    end
    assign err_cond = ovr_set || (rx_push && (framing_flag_cur
        || (parity_flag_cur && !nine_bits))); // [RULE18] [RULE16]

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rx_irq_flag <= 1'b0;
            error_irq <= 1'b0;
            status <= '0;
            rx_data <= '0;
        end else begin
            rx_irq_flag <= rx_push && rx_irq_cond;
            error_irq <= err_cond;
            status.receiver_idle <= (rx_state_next == RX_IDLE); // [RULE21]
            status.rx_data_available <= rx_head_valid; // [RULE22]
            status.overrun_flag <= overrun_reg;
            status.framing_flag <= rx_head_valid && rx_head.framing_err;
            status.parity_flag <= rx_head_valid && rx_head.parity_err
                && !nine_bits; // [RULE16]
            rx_data <= rx_head_valid ? rx_head.data : '0;
        end
    end

    // ------------------------------------------------------------
    // Transmit path with break generation.
    // ------------------------------------------------------------
    tx_state_t tx_state_reg, tx_state_next;
    logic [TX_FRAME_W-1:0] tx_frame_reg, tx_frame_next;
    logic [3:0] tx_left_reg, tx_left_next;
    logic [4:0] tx_phase_reg, tx_phase_next;
    logic tx_brk_reg, tx_brk_next, brk_req_next;
    logic tx_load, tx_done, tx_f_valid, tx_run, tx_ninth;
    logic [DATA_W-1:0] tx_f_data;
    logic [TCW-1:0] tx_count;

    data_fifo #(.WIDTH(DATA_W), .DEPTH(TX_DEPTH)) tx_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .flush(1'b0),
        .in_valid(tx_valid),
        .in_ready(),
        .in_data(tx_data),
        .out_valid(tx_f_valid),
        .out_ready(tx_load),
        .out_data(tx_f_data),
        .count(tx_count)
    );

    assign tx_run = module_enable && transmit_enable;
    assign tx_load = tx_run && (tx_state_reg == TX_IDLE) && tx_f_valid;
    assign tx_done = (tx_state_reg == TX_SHIFT) && sample_tick
        && (tx_phase_reg == ticks_per_bit) && (tx_left_reg == 4'h1);

    always_comb begin
        case (data_parity_sel)
            PSEL_EVEN: tx_ninth = ^tx_f_data[7:0];
            PSEL_ODD: tx_ninth = ~^tx_f_data[7:0];
            PSEL_NINE: tx_ninth = tx_f_data[8];
            default: tx_ninth = 1'b1;
        endcase
    end

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_frame_next = tx_frame_reg;
        tx_left_next = tx_left_reg;
        tx_phase_next = tx_phase_reg;
        tx_brk_next = tx_brk_reg;
        case (tx_state_reg)
            TX_IDLE: begin
                if (tx_load) begin
                    tx_state_next = TX_SHIFT;
                    tx_phase_next = 5'h01;
                    tx_brk_next = break_request; // [RULE2] [RULE4]
                    if (break_request) begin
                        // Written value is dropped: start plus twelve zeros.
                        tx_frame_next = TX_FRAME_W'({1'b1,
                            {(BREAK_ZERO_BITS + 4'h1){1'b0}}}); // [RULE1]
                        tx_left_next = BREAK_FRAME_LEN;
                    end else begin
                        tx_frame_next = {4'hF, tx_ninth, tx_f_data[7:0], 1'b0};
                        tx_left_next = CHAR_BASE_LEN
                            + {3'h0, data_parity_sel != PSEL_NONE}
                            + {3'h0, stop_bits_sel};
                    end
                end
            end
            TX_SHIFT: begin
                if (sample_tick) begin
                    tx_phase_next = tx_phase_reg + 5'h01;
                    if (tx_phase_reg == ticks_per_bit) begin
                        tx_phase_next = 5'h01;
                        tx_frame_next = {1'b1, tx_frame_reg[TX_FRAME_W-1:1]};
                        tx_left_next = tx_left_reg - 4'h1;
                        if (tx_left_reg == 4'h1) begin
                            tx_state_next = TX_IDLE;
                            tx_brk_next = 1'b0;
                        end
                    end
                end
            end
            default: tx_state_next = TX_IDLE;
        endcase
        // Dropping the enable aborts and resets the transmitter.
        if (!tx_run) begin
            tx_state_next = TX_IDLE;
            tx_frame_next = '1;
            tx_brk_next = 1'b0;
        end
    end

    // A new request wins over the end-of-break clear.
    assign brk_req_next = break_set
        || (break_request && !(tx_done && tx_brk_reg)); // [RULE3]

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_state_reg <= TX_IDLE;
            tx_frame_reg <= '1;
            tx_left_reg <= '0;
            tx_phase_reg <= 5'h01;
            tx_brk_reg <= 1'b0;
            break_request <= 1'b0;
            shift_empty <= 1'b1;
            serial_out_pin <= 1'b1;
            serial_out_oe <= 1'b0;
            tx_irq_flag <= 1'b0;
            tx_ready <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_frame_reg <= tx_frame_next;
            tx_left_reg <= tx_left_next;
            tx_phase_reg <= tx_phase_next;
            tx_brk_reg <= tx_brk_next;
            break_request <= brk_req_next;
            shift_empty <= (tx_state_next == TX_IDLE); // [RULE7] [RULE24]
            serial_out_pin <= tx_frame_next[0];
            serial_out_oe <= module_enable;
            tx_irq_flag <= tx_done && !tx_brk_reg; // [RULE5]
            // Registered copy of the FIFO's room, so the port is a flop.
            tx_ready <= (tx_count + TCW'(tx_valid && tx_ready)
                - TCW'(tx_load)) != TCW'(TX_DEPTH);
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_brk_frame_len: assert property ( // [RULE1]
        $rose(tx_brk_reg) |-> tx_left_reg == BREAK_FRAME_LEN
    ) else $error("break frame length wrong");
    a_brk_zero_line: assert property ( // [RULE2]
        tx_brk_reg && tx_left_reg > 4'h1 |-> !serial_out_pin
    ) else $error("break sent a one before its stop bit");
    a_brk_hw_clear: assert property ( // [RULE3]
        $fell(break_request) |-> shift_empty && $past(tx_brk_reg)
    ) else $error("break request cleared early");
    a_brk_no_irq: assert property ( // [RULE5]
        $fell(break_request) |-> !tx_irq_flag
    ) else $error("break raised transmit interrupt");
    a_shift_busy: assert property ( // [RULE7]
        break_request && !serial_out_pin |-> !shift_empty
    ) else $error("shift_empty high while shifting");
    a_ovr_block: assert property ( // [RULE13]
        overrun_reg |=> rx_count <= $past(rx_count)
    ) else $error("transfer while overrun set");
    a_ovr_flush: assert property ( // [RULE14]
        overrun_reg && overrun_clear && !ovr_set |=> rx_count == '0
    ) else $error("overrun clear kept FIFO words");
    a_irq_full_only: assert property ( // [RULE19]
        rx_push && rx_irq_select == RXI_FULL
        && rx_count != RCW'(RX_DEPTH - 1) |=> !rx_irq_flag
    ) else $error("full-level interrupt below full");
    a_avail_flag: assert property ( // [RULE22]
        rx_count != '0 |=> status.rx_data_available
    ) else $error("data available flag low with data");
    a_idle_flag: assert property ( // [RULE21]
        rx_state_reg == RX_DATA |-> ##1 !status.receiver_idle [*2]
    ) else $error("receiver idle while shifting");

    c_break_done: cover property (tx_done && tx_brk_reg);
    c_overrun: cover property (ovr_set);
    c_framing: cover property (rx_push && framing_flag_cur);
    c_full_irq: cover property (rx_irq_flag && rx_full);
endmodule : uart_rx_brk

// ---- verilog/uart_rx_brk_pkg.sv ----
// Constants, types and enumerations shared by the receiver and break logic.
// Overview of operation
// RULE1: A break frame is one start bit, twelve zero bits, then a stop bit.
// RULE2: Break request with transmit enabled turns the next load into zeros only.
// RULE3: Hardware clears break_request after the break stop bit leaves the line.
// RULE4: A pending break request overrides any other transmitter activity; the code only replaces the next loaded word, a shifting character finishes.
// RULE5: A finished break frame raises no transmit interrupt.
// RULE6: Software waits for shift_empty before break, never clears it mid-break.
// RULE7: shift_empty follows the shift register during a break as usual.
// RULE8: A header is break request, one dummy write, then the 0x55 sync byte.
// RULE9: In 16x mode a bit is sixteen ticks, majority of ticks 7, 8, 9.
// RULE10: In 4x mode a bit is four ticks, sampled once at half width.
// RULE11: After the stop sample the assembled word moves into the receive FIFO.
// RULE12: The receive FIFO holds four 9-bit words, oldest read first.
// RULE13: A word completing into a full FIFO sets overrun and blocks transfers.
// RULE14: Clearing overrun empties the receive FIFO.
// RULE15: framing_flag (status bit 2) is set when the stop sample is low.
// RULE16: parity_flag (status bit 3) marks a head word with wrong parity.
// RULE17: Framing and parity indications travel with each FIFO entry.
// RULE18: Any overrun, framing or parity error raises the error interrupt.
// RULE19: Receive interrupt per transfer: 00/01 always, 10 at 3-4, 11 on full.
// RULE20: rx_irq_select may change at run time, acting on later transfers.
// RULE21: receiver_idle (status bit 4) is high while the shift register is empty.
// RULE22: rx_data_available (status bit 0) is high while the FIFO holds data.
// RULE23: data_parity_sel 11 selects nine data bits without parity.
// RULE24: shift_empty is high whenever the transmit shift register is empty.
// RULE25: Reception starts on a falling edge, aligning the sample counter to it.
package uart_rx_brk_pkg;

    localparam int DATA_W = 9;
    localparam int RX_FIFO_DEPTH = 4;
    localparam int TX_FIFO_DEPTH = 8;
    localparam int TX_FRAME_W = 14;

    // Sample ticks per bit and the ticks on which a bit is judged.
    localparam logic [4:0] TICKS_16X = 5'h10;
    localparam logic [4:0] TICKS_4X = 5'h04;
    localparam logic [4:0] MAJ_FIRST = 5'h07;
    localparam logic [4:0] MAJ_SECOND = 5'h08;
    localparam logic [4:0] MAJ_THIRD = 5'h09;
    localparam logic [4:0] HALF_4X = 5'h02;

    localparam logic [3:0] BREAK_ZERO_BITS = 4'hC;
    localparam logic [3:0] BREAK_FRAME_LEN = 4'hE;
    localparam logic [3:0] CHAR_BASE_LEN = 4'hA;
    localparam logic [3:0] RX_BITS_8 = 4'h8;
    localparam logic [3:0] RX_BITS_9 = 4'h9;

    localparam logic [1:0] PSEL_NONE = 2'h0;
    localparam logic [1:0] PSEL_EVEN = 2'h1;
    localparam logic [1:0] PSEL_ODD = 2'h2;
    localparam logic [1:0] PSEL_NINE = 2'h3;

    localparam logic [1:0] RXI_THREE = 2'h2;
    localparam logic [1:0] RXI_FULL = 2'h3;
    localparam logic [2:0] RX_LEVEL_THREE = 3'h3;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_t;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } tx_state_t;

    typedef struct packed {
        logic parity_err;
        logic framing_err;
        logic [DATA_W-1:0] data;
    } rx_entry_t;

    typedef struct packed {
        logic receiver_idle;
        logic parity_flag;
        logic framing_flag;
        logic overrun_flag;
        logic rx_data_available;
    } rx_status_t;

endpackage : uart_rx_brk_pkg

// ---- tb/serial_node.sv ----
// Model of the remote serial node that drives the receive line.
`timescale 1ns/1ps
module serial_node (
    input wire logic mclk, // System clock.
    input wire logic sample_tick, // Sample enable at 16x or 4x rate.
    output logic line // Serial line towards the receiver.
);
    initial line = 1'b1;
    // Sends frame bits LSB first, each tpb ticks, then idles high.
    task automatic send(input logic [11:0] f, input int n, input int tpb);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk iff sample_tick);
            #1 line = f[i];
            repeat (tpb - 1) @(posedge mclk iff sample_tick);
        end
        @(posedge mclk iff sample_tick);
        #1 line = 1'b1;
    endtask : send
endmodule : serial_node

// ---- tb/uart_rx_brk_bench.sv ----
// Self-checking bench for the receiver and break transmitter.
`timescale 1ns/1ps
module uart_rx_brk_bench;
    import uart_rx_brk_pkg::*;
    logic mclk = 0, rstn = 0, sample_tick = 0, transmit_enable = 0;
    logic high_speed_sel = 0, break_set = 0, tx_valid = 0, rx_read = 0;
    logic overrun_clear = 0, serial_in_pin, tx_ready, shift_empty;
    logic break_request, serial_out_pin, rx_irq_flag, error_irq, tx_irq_flag;
    logic [1:0] data_parity_sel = 0, rx_irq_select = 0;
    logic [8:0] tx_data = 0, rx_data;
    rx_status_t status;
    logic serial_out_oe;
    int err_total = 0, tests_run = 0, irq_n = 0, err_n = 0, txi_n = 0, n, k;
    always #25 mclk = ~mclk;
    always @(posedge mclk) sample_tick <= #1 ~sample_tick;
    always @(posedge mclk) begin
        if (rx_irq_flag === 1'b1) irq_n++;
        if (error_irq === 1'b1) err_n++;
        if (tx_irq_flag === 1'b1) txi_n++;
    end
    uart_rx_brk uart_rx_brk_inst (.mclk, .rstn, .sample_tick,
        .module_enable(1'b1), .transmit_enable, .high_speed_sel,
        .data_parity_sel, .stop_bits_sel(1'b0), .rx_irq_select, .break_set,
        .serial_in_pin, .tx_valid, .tx_data, .tx_ready, .rx_read,
        .overrun_clear, .rx_data, .status, .shift_empty, .break_request,
        .serial_out_pin, .serial_out_oe, .rx_irq_flag, .error_irq,
        .tx_irq_flag);
    serial_node serial_node_inst (.mclk, .sample_tick, .line(serial_in_pin));
    // ----------------------------------------------------------------
    // Access tasks.
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic rx(input logic [11:0] f, input int b, input int tpb);
        serial_node_inst.send(f, b, tpb);
        cyc(6);
    endtask : rx
    task automatic pop;
        rx_read = 1;
        cyc(1);
        rx_read = 0;
        cyc(3);
    endtask : pop
    // Leaves tx_valid high so that a following word goes back to back.
    task automatic tx(input logic [8:0] d);
        tx_data = d;
        tx_valid = 1;
        while (tx_ready !== 1'b1) cyc(1);
        cyc(1);
    endtask : tx
    task automatic low_ticks(output int t);
        t = 0;
        while (serial_out_pin !== 1'b0) cyc(1);
        while (serial_out_pin === 1'b0) begin
            if (sample_tick) t++;
            cyc(1);
        end
    endtask : low_ticks
    task automatic print_verdict;
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial begin
        #2000000;
        err_total++;
        print_verdict();
    end
    initial begin
        cyc(3);
        rstn = 1;
        cyc(2);
        chk("status", 9'h010, {4'h0, status});
        chk("shift_empty", 9'h001, {8'h00, shift_empty});
        chk("oe", 9'h001, {8'h00, serial_out_oe});
        chk("rx_data", 9'h000, rx_data);
        rx(12'h34A, 10, 16);
        chk("rx_data", 9'h0A5, rx_data);
        chk("status", 9'h011, {4'h0, status});
        chk("rx_irq", 9'h001, 9'(irq_n));
        pop();
        chk("status", 9'h010, {4'h0, status});
        high_speed_sel = 1;
        rx(12'h278, 10, 4);
        chk("rx_data", 9'h03C, rx_data);
        pop();
        high_speed_sel = 0;
        rx(12'h01E, 10, 16);
        chk("status", 9'h015, {4'h0, status});
        chk("err_irq", 9'h001, 9'(err_n));
        pop();
        data_parity_sel = 2'h1;
        rx(12'h402, 11, 16);
        chk("status", 9'h019, {4'h0, status});
        pop();
        chk("status", 9'h010, {4'h0, status});
        data_parity_sel = 2'h2;
        rx(12'h402, 11, 16);
        chk("status", 9'h011, {4'h0, status});
        pop();
        data_parity_sel = 2'h3;
        rx(12'h754, 11, 16);
        chk("rx_data", 9'h1AA, rx_data);
        chk("err_irq", 9'h002, 9'(err_n));
        pop();
        data_parity_sel = 2'h0;
        k = irq_n;
        for (int i = 0; i < 4; i++) begin
            rx_irq_select = 2'h2 | 2'(i & 1);
            rx({3'b001, 8'(i + 1), 1'b0}, 10, 16);
        end
        chk("rx_irq", 9'h002, 9'(irq_n - k));
        rx(12'h2EE, 10, 16);
        chk("overrun", 9'h001, {8'h00, status.overrun_flag});
        chk("rx_data", 9'h001, rx_data);
        chk("err_irq", 9'h003, 9'(err_n));
        overrun_clear = 1;
        cyc(1);
        overrun_clear = 0;
        cyc(3);
        chk("flush", 9'h000, {7'h00, status[1:0]});
        rx_irq_select = 2'h0;
        transmit_enable = 1;
        while (shift_empty !== 1'b1) cyc(1);
        break_set = 1;
        cyc(1);
        break_set = 0;
        tx(9'h0FF);
        tx(9'h055);
        tx_valid = 0;
        low_ticks(n);
        chk("break_len", 9'h001, 9'(n >= 206 && n <= 210));
        chk("brk_req", 9'h001, {8'h00, break_request});
        chk("shift_empty", 9'h000, {8'h00, shift_empty});
        low_ticks(n);
        chk("sync_start", 9'h001, 9'(n >= 14 && n <= 18));
        chk("brk_req", 9'h000, {8'h00, break_request});
        chk("tx_irq", 9'h000, 9'(txi_n));
        while (shift_empty !== 1'b1) cyc(1);
        cyc(3);
        chk("tx_irq", 9'h001, 9'(txi_n));
        print_verdict();
    end
endmodule : uart_rx_brk_bench
